// ---- design/digitizer_pkg.sv ----
// Shared constants and types for the charge digitizer channel and its readout controller
package digitizer_pkg;
  localparam int TAG_W = 2;
  localparam int RANGE_W = 3;
  localparam int MANT_W = 8;
  localparam int NUM_RANGES = 8;
  localparam int NUM_SETS = 4;
  localparam int WORD_W = TAG_W + RANGE_W + MANT_W;
  localparam int MANT_LSB = 0;
  localparam int RANGE_LSB = MANT_LSB + MANT_W;
  localparam int TAG_LSB = RANGE_LSB + RANGE_W;
  localparam int FIFO_DEPTH = 1024;
  localparam int FIFO_AW = 10;
  localparam int COUNT_W = FIFO_AW + 1;
  localparam int COSMIC_BURST = 8;
  localparam int RESX_BURST = 8;
  localparam int BURST_W = 4;
  localparam int LIN_W = 16;
  localparam int SLOPE_W = 8;
  localparam int CAL_AW = TAG_W + RANGE_W;
  localparam logic [1:0] PH_INTEGRATE = 2'h0;
  localparam logic [1:0] PH_SELECT = 2'h1;
  localparam logic [1:0] PH_DIGITIZE = 2'h2;
  localparam logic [1:0] PH_RESET = 2'h3;
  localparam logic [WORD_W-1:0] WORD_RST = 13'h0000;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_SPILL = 2'b01,
    MODE_COSMIC = 2'b10,
    MODE_RESX = 2'b11
  } acq_mode_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_STROBE = 2'b01,
    RD_WAIT = 2'b10,
    RD_DONE = 2'b11
  } read_state_e;
endpackage : digitizer_pkg

// ---- design/charge_link.sv ----
// Link between the digitizer channel and the readout controller
interface charge_link;
  digitizer_pkg::acq_mode_e acqMode;
  logic spillActive;
  logic dynodeTrig;
  logic readoutActive;
  logic readStrobe;
  logic [digitizer_pkg::WORD_W-1:0] readData;
  logic readValid;
  logic fifoEmpty;
  logic [digitizer_pkg::COUNT_W-1:0] fifoCount;
  logic overflow;

  modport dev (
    input acqMode,
    input spillActive,
    input dynodeTrig,
    input readoutActive,
    input readStrobe,
    output readData,
    output readValid,
    output fifoEmpty,
    output fifoCount,
    output overflow
  );

  modport host (
    output acqMode,
    output spillActive,
    output dynodeTrig,
    output readoutActive,
    output readStrobe,
    input readData,
    input readValid,
    input fifoEmpty,
    input fifoCount,
    input overflow
  );
endinterface : charge_link

// ---- design/charge_digitizer.sv ----
// Digitizer channel: capacitor rotation, range select, word forming and local FIFO
// What this block does
// - Readout passes only samples above threshold
// - Pick one of eight ranges, 3-bit code
// - Integrate, select, digitize, reset, one cycle each
// - Four capacitor sets rotate every clock
// - Result emerges three cycles after integration
// - Range code shown during digitization cycle
// - Converter clocked at end of digitization
// - Each word tagged with its capacitor set
// - Word is tag, range, mantissa: 13 bits
// - Downstream linearizes per range and set
// - Conversion runs continuously, one word per clock
// - Write FIFO only when mode enables it
// - Local buffer holds 1024 words
// - No write while a readout runs
// - Controller alone generates every FIFO read
// - Words stay buffered until readout begins
// - Spill mode writes every clock during spill
// - Cosmic trigger writes short burst
// - Extraction trigger in spill writes fixed burst
// - All FIFOs write in lockstep; mismatch flagged
module charge_digitizer #(
  parameter int DEPTH = digitizer_pkg::FIFO_DEPTH,
  parameter int AW = digitizer_pkg::FIFO_AW,
  parameter int COSMIC_LEN = digitizer_pkg::COSMIC_BURST,
  parameter int RESX_LEN = digitizer_pkg::RESX_BURST
) (
  input wire logic mclk,
  input wire logic arst_n,
  charge_link.dev link,
  input wire logic [digitizer_pkg::NUM_RANGES-1:0] rangeInWindow,
  input wire logic [digitizer_pkg::MANT_W-1:0] flashData,
  output logic [digitizer_pkg::NUM_SETS-1:0] setIntegrate,
  output logic [digitizer_pkg::NUM_SETS-1:0] setSelect,
  output logic [digitizer_pkg::NUM_SETS-1:0] setDigitize,
  output logic [digitizer_pkg::NUM_SETS-1:0] setReset,
  output logic [digitizer_pkg::RANGE_W-1:0] rangeOut,
  output logic [digitizer_pkg::TAG_W-1:0] capSetTagOut,
  output logic flashConvert,
  output logic [digitizer_pkg::WORD_W-1:0] wordOut,
  output logic wordValid
);
  logic [digitizer_pkg::TAG_W-1:0] phaseCnt_reg;
  logic [digitizer_pkg::RANGE_W-1:0] rangeNext;
  logic [digitizer_pkg::TAG_W-1:0] integTag;
  logic [digitizer_pkg::WORD_W-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic [AW:0] fillCount;
  logic fifoFull;
  logic fifoEmptyNow;
  logic dynPrev_reg;
  logic dynRise;
  logic [digitizer_pkg::BURST_W-1:0] burstLeft_reg;
  logic gateOpen;
  logic writeNow;
  logic readoutPrev_reg;
  logic readoutStart;

  // Phase counter: set k is in phase (phaseCnt - k) mod 4
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phaseCnt_reg <= 2'h0;
    end else begin
      phaseCnt_reg <= phaseCnt_reg + 2'h1;
    end
  end

  assign integTag = phaseCnt_reg;

  // One-hot phase strobes for each capacitor set, registered
  genvar gs;
  generate
    for (gs = 0; gs < digitizer_pkg::NUM_SETS; gs++) begin : g_set
      logic [digitizer_pkg::TAG_W-1:0] nextPhase;
      assign nextPhase = phaseCnt_reg + 2'h1 - digitizer_pkg::TAG_W'(gs);
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          setIntegrate[gs] <= 1'b0;
          setSelect[gs] <= 1'b0;
          setDigitize[gs] <= 1'b0;
          setReset[gs] <= 1'b0;
        end else begin
          setIntegrate[gs] <= (nextPhase == digitizer_pkg::PH_INTEGRATE);
          setSelect[gs] <= (nextPhase == digitizer_pkg::PH_SELECT);
          setDigitize[gs] <= (nextPhase == digitizer_pkg::PH_DIGITIZE);
          setReset[gs] <= (nextPhase == digitizer_pkg::PH_RESET);
        end
      end
    end
  endgenerate

  // Lowest range whose level lies in the converter window wins
  always_comb begin
    rangeNext = '0;
    for (int r = digitizer_pkg::NUM_RANGES - 1; r >= 0; r--) begin
      if (rangeInWindow[r]) begin
        rangeNext = digitizer_pkg::RANGE_W'(r);
      end
    end
  end

  // Code and tag latched at end of select, so they stand through digitization
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rangeOut <= '0;
      capSetTagOut <= '0;
    end else begin
      rangeOut <= rangeNext;
      capSetTagOut <= integTag - 2'h1;
    end
  end

  // Converter strobe enable; the edge ending digitization samples the level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flashConvert <= 1'b0;
    end else begin
      flashConvert <= 1'b1;
    end
  end

  // Reset stage: form the floating-point word, three cycles after integration
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wordOut <= digitizer_pkg::WORD_RST;
      wordValid <= 1'b0;
    end else begin
      wordOut <= {capSetTagOut, rangeOut, flashData};
      wordValid <= flashConvert;
    end
  end

  // Spill and trigger come already synchronised by the controller
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dynPrev_reg <= 1'b0;
    end else begin
      dynPrev_reg <= link.dynodeTrig;
    end
  end

  assign dynRise = link.dynodeTrig & ~dynPrev_reg;

  // Burst counter; a trigger inside a burst restarts it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      burstLeft_reg <= '0;
    end else if (link.readoutActive) begin
      burstLeft_reg <= '0;
    end else if (dynRise && link.acqMode == digitizer_pkg::MODE_COSMIC) begin
      burstLeft_reg <= digitizer_pkg::BURST_W'(COSMIC_LEN);
    end else if (dynRise && link.acqMode == digitizer_pkg::MODE_RESX && link.spillActive) begin
      burstLeft_reg <= digitizer_pkg::BURST_W'(RESX_LEN);
    end else if (burstLeft_reg != '0) begin
      burstLeft_reg <= burstLeft_reg - 1'b1;
    end
  end

  always_comb begin
    case (link.acqMode)
      digitizer_pkg::MODE_SPILL: gateOpen = link.spillActive;
      digitizer_pkg::MODE_COSMIC: gateOpen = (burstLeft_reg != '0);
      digitizer_pkg::MODE_RESX: gateOpen = (burstLeft_reg != '0);
      default: gateOpen = 1'b0;
    endcase
  end

  assign fillCount = wrPtr_reg - rdPtr_reg;
  assign fifoFull = (fillCount == (AW + 1)'(DEPTH));
  assign fifoEmptyNow = (fillCount == '0);
  // Write only while the mode gates words in and nobody reads; otherwise the word is lost
  assign writeNow = gateOpen & wordValid & ~link.readoutActive & ~fifoFull;

  // Gate is a pure function of mode and sync'd pins, so all channels write alike
  always_ff @(posedge mclk) begin
    if (writeNow) begin
      mem[wrPtr_reg[AW-1:0]] <= wordOut;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_reg <= '0;
    end else if (writeNow) begin
      wrPtr_reg <= wrPtr_reg + 1'b1;
    end
  end

  // Reads come only from the controller's strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdPtr_reg <= '0;
      link.readData <= digitizer_pkg::WORD_RST;
      link.readValid <= 1'b0;
    end else begin
      link.readValid <= 1'b0;
      if (link.readStrobe && link.readoutActive && !fifoEmptyNow) begin
        link.readData <= mem[rdPtr_reg[AW-1:0]];
        link.readValid <= 1'b1;
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end

  assign readoutStart = link.readoutActive & ~readoutPrev_reg;

  // Overflow: set only outside readout, so the clearing cycle at readout start always clears the flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      readoutPrev_reg <= 1'b0;
      link.overflow <= 1'b0;
    end else begin
      readoutPrev_reg <= link.readoutActive;
      if (gateOpen && wordValid && fifoFull && !link.readoutActive) begin
        link.overflow <= 1'b1;
      end else if (readoutStart) begin
        link.overflow <= 1'b0;
      end
    end
  end

  // Status is registered so it matches the read data timing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.fifoEmpty <= 1'b1;
      link.fifoCount <= '0;
    end else begin
      link.fifoEmpty <= fifoEmptyNow;
      link.fifoCount <= digitizer_pkg::COUNT_W'(fillCount);
    end
  end
endmodule : charge_digitizer

// ---- design/readout_controller.sv ----
// Readout controller: mode control, FIFO readout, linearization and threshold
module readout_controller (
  input wire logic mclk,
  input wire logic arst_n,
  charge_link.host link,
  input wire digitizer_pkg::acq_mode_e modeIn,
  input wire logic spillIn,
  input wire logic dynodeIn,
  input wire logic startReadout,
  input wire logic [digitizer_pkg::COUNT_W-1:0] refCount,
  input wire logic [digitizer_pkg::LIN_W-1:0] threshold,
  input wire logic calWrite,
  input wire logic [digitizer_pkg::CAL_AW-1:0] calAddr,
  input wire logic [digitizer_pkg::SLOPE_W-1:0] calSlope,
  input wire logic [digitizer_pkg::LIN_W-1:0] calOffset,
  output logic [digitizer_pkg::LIN_W-1:0] linData,
  output logic [digitizer_pkg::TAG_W-1:0] linTag,
  output logic linValid,
  output logic busy,
  output logic countError
);
  digitizer_pkg::read_state_e state_reg;
  logic [digitizer_pkg::SLOPE_W-1:0] slopeMem [2**digitizer_pkg::CAL_AW];
  logic [digitizer_pkg::LIN_W-1:0] offsetMem [2**digitizer_pkg::CAL_AW];
  logic [digitizer_pkg::CAL_AW-1:0] lutIdx;
  logic [digitizer_pkg::LIN_W-1:0] product;
  logic [digitizer_pkg::LIN_W-1:0] linValue;
  logic spillMeta_reg;
  logic dynMeta_reg;

  // Spill and trigger are asynchronous pins: two flops, the link side is the second
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.acqMode <= digitizer_pkg::MODE_IDLE;
      spillMeta_reg <= 1'b0;
      dynMeta_reg <= 1'b0;
      link.spillActive <= 1'b0;
      link.dynodeTrig <= 1'b0;
    end else begin
      link.acqMode <= modeIn;
      spillMeta_reg <= spillIn;
      dynMeta_reg <= dynodeIn;
      link.spillActive <= spillMeta_reg;
      link.dynodeTrig <= dynMeta_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (calWrite) begin
      slopeMem[calAddr] <= calSlope;
      offsetMem[calAddr] <= calOffset;
    end
  end

  // Start is ignored while the spill is active; one strobe per word, then wait for data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= digitizer_pkg::RD_IDLE;
      link.readoutActive <= 1'b0;
      link.readStrobe <= 1'b0;
      busy <= 1'b0;
      countError <= 1'b0;
    end else begin
      link.readStrobe <= 1'b0;
      case (state_reg)
        digitizer_pkg::RD_IDLE: begin
          if (startReadout && !link.spillActive) begin
            state_reg <= digitizer_pkg::RD_WAIT;
            link.readoutActive <= 1'b1;
            busy <= 1'b1;
            countError <= (link.fifoCount != refCount);
          end
        end
        digitizer_pkg::RD_STROBE: begin
          link.readStrobe <= 1'b1;
          state_reg <= digitizer_pkg::RD_WAIT;
        end
        digitizer_pkg::RD_WAIT: begin
          if (!link.readStrobe && !link.readValid) begin
            state_reg <= link.fifoEmpty ? digitizer_pkg::RD_DONE : digitizer_pkg::RD_STROBE;
          end
        end
        digitizer_pkg::RD_DONE: begin
          link.readoutActive <= 1'b0;
          busy <= 1'b0;
          state_reg <= digitizer_pkg::RD_IDLE;
        end
        default: state_reg <= digitizer_pkg::RD_IDLE;
      endcase
    end
  end

  // Table index is tag and range together, the word's top five bits
  assign lutIdx = link.readData[digitizer_pkg::RANGE_LSB +: digitizer_pkg::CAL_AW];
  // Slope times mantissa; overflow beyond 16 bits wraps, calibration must avoid it
  assign product = digitizer_pkg::LIN_W'(slopeMem[lutIdx]
    * link.readData[digitizer_pkg::MANT_LSB +: digitizer_pkg::MANT_W]);
  assign linValue = digitizer_pkg::LIN_W'(offsetMem[lutIdx] + product);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      linData <= '0;
      linTag <= '0;
      linValid <= 1'b0;
    end else begin
      linData <= linValue;
      linTag <= link.readData[digitizer_pkg::TAG_LSB +: digitizer_pkg::TAG_W];
      linValid <= link.readValid && (linValue > threshold);
    end
  end
endmodule : readout_controller

// ---- test/pipelined_charge_digitizer_fifo_chk.sv ----
// Link assertions between digitizer channel and readout controller
module pipelined_charge_digitizer_fifo_chk #(
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic readoutActive,
  input wire logic readStrobe,
  input wire logic readValid,
  input wire logic fifoEmpty,
  input wire logic [digitizer_pkg::COUNT_W-1:0] fifoCount,
  input wire logic overflow
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  chk_strobe_in_readout: assert property (readStrobe |-> readoutActive)
    else $error("read strobe outside readout");
  chk_strobe_one_cycle: assert property (readStrobe |=> !readStrobe)
    else $error("read strobe longer than one cycle");
  chk_valid_after_strobe: assert property (readStrobe |=> readValid)
    else $error("no read data after strobe");
  chk_valid_has_cause: assert property (readValid |-> $past(readStrobe))
    else $error("read data without strobe");
  chk_count_bound: assert property (fifoCount <= DEPTH)
    else $error("fifo count above depth");
  // Three cycles of slack: count status lags the write gate
  chk_no_fill_readout: assert property (
    readoutActive && $past(readoutActive, 3) |-> fifoCount <= $past(fifoCount))
    else $error("fifo grew during readout");
  chk_overflow_sticky: assert property (overflow && !readoutActive |=> overflow)
    else $error("overflow dropped outside readout");
  chk_overflow_not_empty: assert property (overflow |-> !fifoEmpty)
    else $error("overflow with empty fifo");
  chk_empty_count: assert property (fifoEmpty == (fifoCount == 11'h000))
    else $error("empty flag disagrees with count");
endmodule : pipelined_charge_digitizer_fifo_chk

// ---- test/pipelined_charge_digitizer_fifo_tb.sv ----
// Testbench joining digitizer channel and readout controller
module pipelined_charge_digitizer_fifo_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] rangeInWindow = 8'h00;
  logic [7:0] flashData = 8'h00;
  digitizer_pkg::acq_mode_e modeIn = digitizer_pkg::MODE_IDLE;
  logic spillIn = 1'b0;
  logic dynodeIn = 1'b0;
  logic startReadout = 1'b0;
  logic [10:0] refCount = 11'h000;
  logic [15:0] threshold = 16'h0000;
  logic calWrite = 1'b0;
  logic [4:0] calAddr = 5'h00;
  logic [7:0] calSlope = 8'h00;
  logic [15:0] calOffset = 16'h0000;
  logic [3:0] setIntegrate, setSelect, setDigitize, setReset;
  logic [12:0] wordOut;
  logic [2:0] rangeOut;
  logic [1:0] capSetTagOut;
  logic flashConvert;
  logic wordValid, linValid, busy, countError;
  logic [15:0] linData;
  logic [1:0] linTag;
  int mismatches = 0;
  int compares = 0;
  int rdCnt = 0;
  int seen = 0;
  logic chainOn = 1'b0;
  logic [1:0] prevTag, prevRd;
  logic [12:0] expWord;
  logic [7:0] riwPrev = 8'h00;
  logic [15:0] e;
  logic [31:0] rs = 32'h957E;
  logic [15:0] linQ[$];

  always #20 mclk = ~mclk;

  charge_link link ();
  charge_digitizer #(.DEPTH(DEPTH), .AW(4)) u_charge_digitizer (.mclk(mclk), .arst_n(arst_n),
    .link(link), .rangeInWindow(rangeInWindow), .flashData(flashData),
    .setIntegrate(setIntegrate), .setSelect(setSelect), .setDigitize(setDigitize),
    .setReset(setReset), .rangeOut(rangeOut), .capSetTagOut(capSetTagOut),
    .flashConvert(flashConvert), .wordOut(wordOut),
    .wordValid(wordValid));
  readout_controller u_readout_controller (.mclk(mclk), .arst_n(arst_n), .link(link),
    .modeIn(modeIn), .spillIn(spillIn), .dynodeIn(dynodeIn), .startReadout(startReadout),
    .refCount(refCount), .threshold(threshold), .calWrite(calWrite), .calAddr(calAddr),
    .calSlope(calSlope), .calOffset(calOffset), .linData(linData), .linTag(linTag),
    .linValid(linValid), .busy(busy), .countError(countError));
  pipelined_charge_digitizer_fifo_chk #(.DEPTH(DEPTH)) u_chk (.mclk(mclk), .arst_n(arst_n),
    .readoutActive(link.readoutActive), .readStrobe(link.readStrobe),
    .readValid(link.readValid), .fifoEmpty(link.fifoEmpty), .fifoCount(link.fifoCount),
    .overflow(link.overflow));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic close_out();
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift

  function automatic logic [2:0] enc(input logic [7:0] w);
    enc = 3'h0;
    for (int r = 7; r >= 0; r--) begin
      if (w[r]) enc = 3'(r);
    end
  endfunction : enc

  // Random window and converter data every clock; model of the word pipeline
  always @(posedge mclk) begin
    rs = xorshift(rs);
    expWord <= {2'h0, enc(riwPrev), flashData};
    riwPrev <= rangeInWindow;
    rangeInWindow <= rs[7:0];
    flashData <= rs[15:8];
  end

  always @(negedge mclk) begin
    if (arst_n && wordValid === 1'b1) seen++;
    else seen = 0;
    if (seen > 3) begin
      check("word", {3'h0, prevTag + 2'h1, expWord[10:0]}, {3'h0, wordOut});
      check("reset set", 16'(4'h1 << wordOut[12:11]), {12'h000, setReset});
      check("phases", 16'h000F, {12'h000, setIntegrate | setSelect | setDigitize | setReset});
      check("range code", {13'h0, enc(riwPrev)}, {13'h0, rangeOut});
      check("digitize tag", {14'h0, prevTag + 2'h2}, {14'h0, capSetTagOut});
      check("digitize set", 16'(4'h1 << (prevTag + 2'h2)), {12'h000, setDigitize});
      check("converter strobe", 16'h0001, {15'h0, flashConvert});
    end
    prevTag = wordOut[12:11];
  end

  // Slope one, offset index times 256: linear value equals the raw word
  always @(posedge mclk) begin
    if (link.readValid === 1'b1) begin
      rdCnt++;
      if (chainOn) check("read tag", {14'h0, prevRd + 2'h1}, {14'h0, link.readData[12:11]});
      chainOn = 1'b1;
      prevRd = link.readData[12:11];
      if ({3'h0, link.readData} > threshold) linQ.push_back({3'h0, link.readData});
    end
    if (linValid === 1'b1) begin
      e = (linQ.size() > 0) ? linQ.pop_front() : 16'hXXXX;
      check("lin", e, linData);
      check("lin tag", {14'h0, e[12:11]}, {14'h0, linTag});
    end
  end

  task automatic run(input digitizer_pkg::acq_mode_e m, input int spill, input bit dyn,
                     input int expN, input int refN);
    int n;
    n = (expN > DEPTH) ? DEPTH : expN;
    modeIn <= m;
    repeat (2) @(posedge mclk);
    spillIn <= (spill > 0);
    repeat (2) @(posedge mclk);
    dynodeIn <= dyn;
    @(posedge mclk);
    dynodeIn <= 1'b0;
    repeat (spill) @(posedge mclk);
    spillIn <= 1'b0;
    repeat (12) @(posedge mclk);
    modeIn <= digitizer_pkg::MODE_IDLE;
    refCount <= 11'(refN);
    repeat (6) @(posedge mclk);
    check("overflow", 16'(expN > DEPTH), {15'h0, link.overflow});
    rdCnt = 0;
    chainOn = 1'b0;
    startReadout <= 1'b1;
    @(posedge mclk);
    startReadout <= 1'b0;
    repeat (2) @(posedge mclk);
    while (busy === 1'b1) @(posedge mclk);
    @(negedge mclk);
    check("words", 16'(n), 16'(rdCnt));
    check("count error", 16'(n != refN), {15'h0, countError});
    check("overflow clear", 16'h0000, {15'h0, link.overflow});
    check("left over", 16'h0000, 16'(linQ.size()));
  endtask : run

  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    threshold <= {3'h0, rs[28:16]};
    @(posedge mclk);
    for (int i = 0; i < 32; i++) begin
      calWrite <= 1'b1;
      calAddr <= 5'(i);
      calSlope <= 8'h01;
      calOffset <= 16'(i << 8);
      @(posedge mclk);
    end
    calWrite <= 1'b0;
    run(digitizer_pkg::MODE_SPILL, 7, 1'b0, 10, 10);
    run(digitizer_pkg::MODE_IDLE, 7, 1'b0, 0, 0);
    run(digitizer_pkg::MODE_COSMIC, 0, 1'b1, 8, 9);
    run(digitizer_pkg::MODE_RESX, 9, 1'b1, 8, 8);
    run(digitizer_pkg::MODE_RESX, 0, 1'b1, 0, 0);
    run(digitizer_pkg::MODE_SPILL, 17, 1'b0, 20, 16);
    close_out();
  end

  // Whole run needs about four hundred cycles
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    close_out();
  end
endmodule : pipelined_charge_digitizer_fifo_tb
